// >>> touch_key_detect_filter.sv
// Per-key touch detection: thresholds, drift tracking, detection integrators.
// Assumes an acquisition front end on the same clock answering each request.
//
// How it works
// - Touch threshold sits below the key's reference
// - Threshold follows every reference change
// - Touch hysteresis fixed at one eighth
// - Touch threshold equals setting plus four
// - Rise threshold six counts, one-eighth hysteresis rounds to zero
// - Large rise above reference recalibrates key
// - Rise must persist 200 ms first
// - Reference steps toward signal only untouched
// - Separate falling and rising drift rates
// - Falling rate ten gives 2.5 s steps
// - Rising rate four gives 0.6 s steps
// - Normal limit zero removes key from scan
// - Repeat touched key until fast limit
// - Per-key fast counter, limit 1 to 15
// - Touch sample increments fast counter
// - Untouched sample clears fast counter
// - Normal counter increments once per scan
// - Active when normal counter hits limit
// - Fast limit one means single acquisition
// - Defaults: normal limit 2, fast 5
`timescale 1ns/100ps
module touch_key_detect_filter #(
  parameter int unsigned TICK_CYCLES = touch_key_pkg::TICK_CYCLES  // Cycles per 10 ms tick
) (
  input  wire logic        ref_clk_i,          // 25 MHz clock
  input  wire logic        rst_n_i,            // Async reset, active low
  output logic             acq_req_o,          // Acquisition request, held until valid
  output logic [4:0]       acq_key_o,          // Key to acquire
  input  wire logic        acq_valid_i,        // Front end has a sample
  input  wire logic [15:0] acq_signal_i,       // Sampled key signal
  input  wire logic        cfg_we_i,           // Setting write strobe
  input  wire logic [4:0]  cfg_key_i,          // Key of the setting write
  input  wire logic [2:0]  cfg_field_i,        // Which setting
  input  wire logic [7:0]  cfg_data_i,         // New setting value
  input  wire logic        cal_all_i,          // Recalibrate all enabled keys next scan
  input  wire logic [4:0]  rd_key_i,           // Key to read back
  output logic [15:0]      rd_signal_o,        // Last signal of rd_key_i
  output logic [15:0]      rd_reference_o,     // Reference of rd_key_i
  output logic [3:0]       rd_detect_count_o,  // Normal count of rd_key_i
  output logic [23:0]      key_active_o,       // Confirmed touches
  output logic             scan_done_o         // Pulse at end of a full scan
);

  localparam int unsigned NK = touch_key_pkg::NUM_KEYS;
  localparam logic [4:0] LAST_KEY = 5'(NK - 1);

  typedef enum logic [1:0] {ST_PICK, ST_REQ, ST_EVAL} scan_state_t;

  // Per-key settings
  logic [7:0]  touch_threshold_setting [NK];
  logic [3:0]  falling_drift_rate      [NK];
  logic [3:0]  rising_drift_rate       [NK];
  logic [3:0]  normal_integrator_limit [NK];
  logic [3:0]  fast_integrator_limit   [NK];

  // Per-key processing state
  logic [15:0] signal_mem  [NK];
  logic [15:0] reference_mem [NK];
  logic [3:0]  fast_cnt    [NK];
  logic [3:0]  normal_cnt  [NK];
  // Tick stamps of the last drift step and of a rise start
  logic [15:0] drift_stamp [NK];
  logic [15:0] rise_stamp  [NK];

  // One bit per key
  logic [NK-1:0] active_reg;
  logic [NK-1:0] scan_inc_reg;
  logic [NK-1:0] rise_pend_reg;

  scan_state_t state_reg;
  logic [4:0]  key_ptr_reg;
  logic [15:0] sample_reg;
  logic        cal_pend_reg;
  logic        recal_scan_reg;
  logic [31:0] tick_cnt_reg;
  logic [15:0] now_reg;

  logic        key_enabled;
  logic        advance;
  logic        scan_wrap;
  logic        repeat_key;
  logic        in_touch;
  logic        rise_recal;
  logic        do_recal;
  logic [4:0]  fast_lim;
  logic [4:0]  fast_inc;
  logic [3:0]  normal_inc;
  logic [15:0] drift_elapsed;
  logic [15:0] rise_elapsed;

  key_threshold_if thr ();

  key_threshold_calc u_thr (
    .thr (thr)
  );

  // Fast limit of zero is not legal; treat it as one
  function automatic logic [4:0] limit_of(input logic [3:0] lim);
    limit_of = (lim == 4'h0) ? 5'h01 : {1'b0, lim};
  endfunction

  // Indices past the last key address nothing
  function automatic logic key_in_range(input logic [4:0] key);
    key_in_range = (key <= LAST_KEY);
  endfunction

  // Combinational view of the key under evaluation
  always_comb begin
    key_enabled  = (normal_integrator_limit[key_ptr_reg] != 4'h0);
    // A count in flight already counts as touch for hysteresis and drift
    in_touch     = active_reg[key_ptr_reg] || (fast_cnt[key_ptr_reg] != 4'h0)
                   || (normal_cnt[key_ptr_reg] != 4'h0);
    fast_lim     = limit_of(fast_integrator_limit[key_ptr_reg]);
    fast_inc     = {1'b0, fast_cnt[key_ptr_reg]} + 5'h01;
    normal_inc   = (normal_cnt[key_ptr_reg] == 4'hf) ? 4'hf
                   : normal_cnt[key_ptr_reg] + 4'h1;
    drift_elapsed = now_reg - drift_stamp[key_ptr_reg];
    rise_elapsed  = now_reg - rise_stamp[key_ptr_reg];
    rise_recal   = thr.above_rise && rise_pend_reg[key_ptr_reg]
                   && (rise_elapsed >= touch_key_pkg::RISE_RECAL_TICKS);
    // Recalibration overrides both detection and drift for this sample
    do_recal     = recal_scan_reg || rise_recal;

    // Stay on the key while the fast count has not yet reached its limit
    repeat_key   = (state_reg == ST_EVAL) && !do_recal && thr.below_touch
                   && (fast_inc < fast_lim);
    // A disabled key costs one pick cycle and no request
    advance      = ((state_reg == ST_EVAL) && !repeat_key)
                   || ((state_reg == ST_PICK) && !key_enabled);
    scan_wrap    = advance && (key_ptr_reg == LAST_KEY);
  end

  // The comparator always looks at the key under the pointer
  assign thr.reference    = reference_mem[key_ptr_reg];
  assign thr.signal       = sample_reg;
  assign thr.setting      = touch_threshold_setting[key_ptr_reg];
  assign thr.in_touch     = in_touch;
  assign thr.rise_pending = rise_pend_reg[key_ptr_reg];

  // A pure state decode, so the request drops on the take edge
  assign acq_req_o    = (state_reg == ST_REQ);
  assign acq_key_o    = key_ptr_reg;
  assign key_active_o = active_reg;

  // Time base: one tick each 10 ms, timestamps compared modulo 2^16
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_cnt_reg <= 32'h00000000;
      now_reg      <= 16'h0000;
    end else if (tick_cnt_reg >= 32'(TICK_CYCLES - 1)) begin
      tick_cnt_reg <= 32'h00000000;
      now_reg      <= now_reg + 16'h0001;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
    end
  end

  // Setting storage with factory defaults
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int k = 0; k < NK; k++) begin
        touch_threshold_setting[k] <= touch_key_pkg::TOUCH_THRESHOLD_DEFAULT;
        falling_drift_rate[k]      <= touch_key_pkg::FALLING_DRIFT_DEFAULT;
        rising_drift_rate[k]       <= touch_key_pkg::RISING_DRIFT_DEFAULT;
        normal_integrator_limit[k] <= touch_key_pkg::NORMAL_LIMIT_DEFAULT;
        fast_integrator_limit[k]   <= touch_key_pkg::FAST_LIMIT_DEFAULT;
      end
    end else if (cfg_we_i && key_in_range(cfg_key_i)) begin
      // Unknown fields are dropped without effect
      case (cfg_field_i)
        touch_key_pkg::CFG_TOUCH_THRESHOLD: touch_threshold_setting[cfg_key_i] <= cfg_data_i;
        touch_key_pkg::CFG_FALLING_DRIFT:   falling_drift_rate[cfg_key_i] <= cfg_data_i[3:0];
        touch_key_pkg::CFG_RISING_DRIFT:    rising_drift_rate[cfg_key_i] <= cfg_data_i[3:0];
        touch_key_pkg::CFG_NORMAL_LIMIT:    normal_integrator_limit[cfg_key_i] <= cfg_data_i[3:0];
        touch_key_pkg::CFG_FAST_LIMIT:      fast_integrator_limit[cfg_key_i] <= cfg_data_i[3:0];
        default: ;
      endcase
    end
  end

  // Scan sequencer
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg   <= ST_PICK;
      key_ptr_reg <= 5'h00;
      sample_reg  <= 16'h0000;
      scan_done_o <= 1'b0;
    end else begin
      scan_done_o <= scan_wrap;

      case (state_reg)
        ST_PICK: begin
          if (key_enabled) begin
            state_reg <= ST_REQ;
          end
        end
        ST_REQ: begin
          if (acq_valid_i) begin
            sample_reg <= acq_signal_i;
            state_reg  <= ST_EVAL;
          end
        end
        ST_EVAL: begin
          // A repeat burst skips the pick cycle
          state_reg <= repeat_key ? ST_REQ : ST_PICK;
        end
        default: state_reg <= ST_PICK;
      endcase

      // The pointer moves only outside requests, so acq_key_o stands
      if (advance) begin
        key_ptr_reg <= scan_wrap ? 5'h00 : key_ptr_reg + 5'h01;
      end
    end
  end

  // Recalibrate-all: the whole scan after the request recalibrates every enabled key.
  // Power-up starts with such a scan, since references begin unknown.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cal_pend_reg   <= 1'b0;
      recal_scan_reg <= 1'b1;
    end else begin
      if (scan_wrap) begin
        recal_scan_reg <= cal_pend_reg || cal_all_i;
        cal_pend_reg   <= 1'b0;
      end else if (cal_all_i) begin
        cal_pend_reg   <= 1'b1;
      end
    end
  end

  // Per-key detection, drift and recalibration
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int k = 0; k < NK; k++) begin
        signal_mem[k]    <= 16'h0000;
        reference_mem[k] <= 16'h0000;
        fast_cnt[k]      <= 4'h0;
        normal_cnt[k]    <= 4'h0;
        drift_stamp[k]   <= 16'h0000;
        rise_stamp[k]    <= 16'h0000;
      end
      active_reg    <= '0;
      scan_inc_reg  <= '0;
      rise_pend_reg <= '0;
    end else begin
      if (scan_wrap) begin
        scan_inc_reg <= '0;
      end

      // A disabled key cannot hold a stale touch
      for (int k = 0; k < NK; k++) begin
        if (normal_integrator_limit[k] == 4'h0) begin
          active_reg[k] <= 1'b0;
          fast_cnt[k]   <= 4'h0;
          normal_cnt[k] <= 4'h0;
        end
      end

      if (state_reg == ST_EVAL) begin
        signal_mem[key_ptr_reg] <= sample_reg;
        if (do_recal) begin
          reference_mem[key_ptr_reg] <= sample_reg;
          fast_cnt[key_ptr_reg]      <= 4'h0;
          normal_cnt[key_ptr_reg]    <= 4'h0;
          active_reg[key_ptr_reg]    <= 1'b0;
          rise_pend_reg[key_ptr_reg] <= 1'b0;
          drift_stamp[key_ptr_reg]   <= now_reg;
        end else if (thr.below_touch) begin
          rise_pend_reg[key_ptr_reg] <= 1'b0;
          // Refreshing the stamp makes drift wait anew after release
          drift_stamp[key_ptr_reg]   <= now_reg;
          if (fast_inc >= fast_lim) begin
            fast_cnt[key_ptr_reg] <= 4'h0;
            if (!scan_inc_reg[key_ptr_reg]) begin
              normal_cnt[key_ptr_reg]   <= normal_inc;
              // The last key's mark must not outlive the wrap clear
              scan_inc_reg[key_ptr_reg] <= !scan_wrap;
              if (normal_inc >= normal_integrator_limit[key_ptr_reg]) begin
                active_reg[key_ptr_reg] <= 1'b1;
              end
            end
          end else begin
            fast_cnt[key_ptr_reg] <= fast_inc[3:0];
          end
        end else begin
          fast_cnt[key_ptr_reg]   <= 4'h0;
          normal_cnt[key_ptr_reg] <= 4'h0;
          active_reg[key_ptr_reg] <= 1'b0;
          if (thr.above_rise) begin
            if (!rise_pend_reg[key_ptr_reg]) begin
              rise_pend_reg[key_ptr_reg] <= 1'b1;
              rise_stamp[key_ptr_reg]    <= now_reg;
            end
          end else begin
            rise_pend_reg[key_ptr_reg] <= 1'b0;
          end

          // Drift only when no touch was in effect before this sample
          if (in_touch || (sample_reg == thr.reference)) begin
            drift_stamp[key_ptr_reg] <= now_reg;
          end else if (sample_reg < thr.reference) begin
            if (drift_elapsed >= touch_key_pkg::drift_ticks(falling_drift_rate[key_ptr_reg])) begin
              reference_mem[key_ptr_reg] <= thr.reference - 16'h0001;
              drift_stamp[key_ptr_reg]   <= now_reg;
            end
          end else begin
            if (drift_elapsed >= touch_key_pkg::drift_ticks(rising_drift_rate[key_ptr_reg])) begin
              reference_mem[key_ptr_reg] <= thr.reference + 16'h0001;
              drift_stamp[key_ptr_reg]   <= now_reg;
            end
          end
        end
      end
    end
  end

  // Read-back of one key, registered
  // Unmapped keys read as zero rather than alias a real key
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_signal_o       <= 16'h0000;
      rd_reference_o    <= 16'h0000;
      rd_detect_count_o <= 4'h0;
    end else if (key_in_range(rd_key_i)) begin
      rd_signal_o       <= signal_mem[rd_key_i];
      rd_reference_o    <= reference_mem[rd_key_i];
      rd_detect_count_o <= normal_cnt[rd_key_i];
    end else begin
      rd_signal_o       <= 16'h0000;
      rd_reference_o    <= 16'h0000;
      rd_detect_count_o <= 4'h0;
    end
  end

endmodule

// >>> touch_key_pkg.sv
// Constants, setting defaults and lookup helpers for the touch key filter.
// Assumes a 25 MHz reference clock and a 24-key matrix with 16-bit signals.
package touch_key_pkg;

  localparam int unsigned NUM_KEYS   = 24;
  localparam int unsigned KEY_W      = 5;
  localparam int unsigned SIG_W      = 16;
  localparam int unsigned STAMP_W    = 16;

  // Clock and time base
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned TICK_MS       = 10;
  localparam int unsigned TICK_CYCLES   = (TICK_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned RISE_RECAL_DELAY_MS = 200;
  localparam logic [15:0] RISE_RECAL_TICKS    = 16'(RISE_RECAL_DELAY_MS / TICK_MS);

  // Threshold arithmetic
  localparam logic [8:0]  THRESHOLD_OFFSET     = 9'h004;
  localparam logic [15:0] RISE_THRESHOLD_LEVEL = 16'h0006;
  localparam int unsigned HYST_SHIFT           = 3;

  // Factory defaults of the per-key settings
  localparam logic [7:0] TOUCH_THRESHOLD_DEFAULT   = 8'h06;
  localparam logic [3:0] FALLING_DRIFT_DEFAULT     = 4'ha;
  localparam logic [3:0] RISING_DRIFT_DEFAULT      = 4'h4;
  localparam logic [3:0] NORMAL_LIMIT_DEFAULT      = 4'h2;
  localparam logic [3:0] FAST_LIMIT_DEFAULT        = 4'h5;

  // Setting selector on the configuration port
  typedef enum logic [2:0] {
    CFG_TOUCH_THRESHOLD = 3'h0,
    CFG_FALLING_DRIFT   = 3'h1,
    CFG_RISING_DRIFT    = 3'h2,
    CFG_NORMAL_LIMIT    = 3'h3,
    CFG_FAST_LIMIT      = 3'h4
  } cfg_field_t;

  // Drift rate setting to interval between reference steps, in time-base ticks
  function automatic logic [15:0] drift_ticks(input logic [3:0] rate);
    case (rate)
      4'h0:    drift_ticks = 16'h0005;
      4'h1:    drift_ticks = 16'h000a;
      4'h2:    drift_ticks = 16'h0014;
      4'h3:    drift_ticks = 16'h0028;
      4'h4:    drift_ticks = 16'h003c;
      4'h5:    drift_ticks = 16'h0050;
      4'h6:    drift_ticks = 16'h0064;
      4'h7:    drift_ticks = 16'h0096;
      4'h8:    drift_ticks = 16'h00af;
      4'h9:    drift_ticks = 16'h00c8;
      4'ha:    drift_ticks = 16'h00fa;
      4'hb:    drift_ticks = 16'h014a;
      4'hc:    drift_ticks = 16'h0190;
      4'hd:    drift_ticks = 16'h01f4;
      4'he:    drift_ticks = 16'h02ee;
      default: drift_ticks = 16'h03e8;
    endcase
  endfunction

endpackage

// >>> key_threshold_if.sv
// Carries one key's reference, signal and state to the threshold comparator.
// Assumes both ends sit on the same clock; everything here is combinational.
`timescale 1ns/100ps
interface key_threshold_if;
  logic [15:0] reference;
  logic [15:0] signal;
  logic [7:0]  setting;
  logic        in_touch;
  logic        rise_pending;
  logic        below_touch;
  logic        above_rise;

  modport calc (input reference, signal, setting, in_touch, rise_pending,
                output below_touch, above_rise);
  modport user (output reference, signal, setting, in_touch, rise_pending,
                input below_touch, above_rise);
endinterface

// >>> key_threshold_calc.sv
// Touch and rise comparisons of one key's signal against its reference.
// Assumes the caller holds the inputs stable for the cycle it samples results.
`timescale 1ns/100ps
module key_threshold_calc (
  key_threshold_if.calc thr  // Comparator side of the key's values
);

  logic [17:0] touch_amount;
  logic [17:0] touch_hyst;
  logic [17:0] touch_lhs;
  logic [17:0] touch_rhs;
  logic [17:0] rise_hyst;
  logic [17:0] rise_rhs;

  always_comb begin
    touch_amount = 18'({1'b0, thr.setting}) + 18'(touch_key_pkg::THRESHOLD_OFFSET);
    touch_hyst   = touch_amount >> touch_key_pkg::HYST_SHIFT;
    // Compare sig + amount against ref so a small reference cannot wrap
    touch_lhs    = 18'(thr.signal) + touch_amount;
    touch_rhs    = 18'(thr.reference) + (thr.in_touch ? touch_hyst : 18'h00000);
    rise_hyst    = 18'(touch_key_pkg::RISE_THRESHOLD_LEVEL) >> touch_key_pkg::HYST_SHIFT;
    rise_rhs     = 18'(thr.reference) + 18'(touch_key_pkg::RISE_THRESHOLD_LEVEL)
                   - (thr.rise_pending ? rise_hyst : 18'h00000);
  end

  assign thr.below_touch = (touch_lhs <= touch_rhs);
  assign thr.above_rise  = (18'(thr.signal) > rise_rhs);

endmodule

// >>> touch_key_detect_filter_properties.sv
// Concurrent checks on the touch key filter's top-level ports.
// Assumes a single clock domain; bound onto every filter instance below.
`timescale 1ns/100ps
module touch_key_detect_filter_properties #(
  parameter int unsigned TICK_CYCLES = touch_key_pkg::TICK_CYCLES  // Cycles per tick
) (
  input wire logic        ref_clk_i,          // Clock
  input wire logic        rst_n_i,            // Async reset, active low
  input wire logic        acq_req_o,          // Sample request
  input wire logic [4:0]  acq_key_o,          // Requested key
  input wire logic        acq_valid_i,        // Sample strobe
  input wire logic [4:0]  rd_key_i,           // Read-back key
  input wire logic [15:0] rd_signal_o,        // Read-back signal
  input wire logic [15:0] rd_reference_o,     // Read-back reference
  input wire logic [3:0]  rd_detect_count_o,  // Read-back count
  input wire logic [23:0] key_active_o,       // Confirmed touches
  input wire logic        scan_done_o         // Scan end pulse
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  logic taken;
  assign taken = acq_req_o && acq_valid_i;

  sequence s_taken;
    taken;
  endsequence
  // A request two cycles after a take can only be a repeat burst
  sequence s_quick_rerequest;
    s_taken ##1 !acq_req_o ##1 acq_req_o;
  endsequence

  a_req_held: assert property (acq_req_o && !acq_valid_i |=> acq_req_o && $stable(acq_key_o))
    else $error("Request not held until answered");
  a_req_drop: assert property (s_taken |=> !acq_req_o)
    else $error("Request still high after sample taken");
  a_repeat_same: assert property (s_quick_rerequest |-> acq_key_o == $past(acq_key_o, 2))
    else $error("Quick repeat went to another key");
  a_key_range: assert property (acq_req_o |-> acq_key_o <= 5'h17)
    else $error("Requested key out of range");
  a_done_pulse: assert property (scan_done_o |=> !scan_done_o)
    else $error("Scan done longer than one cycle");
  a_start_idle: assert property (!$past(rst_n_i) |-> !acq_req_o && !scan_done_o)
    else $error("Activity on first edge after reset");
  a_rd_unmapped: assert property (rd_key_i > 5'h17 |=> rd_signal_o == 16'h0000 &&
                                  rd_reference_o == 16'h0000 && rd_detect_count_o == 4'h0)
    else $error("Unmapped read-back not zero");
  a_active_cause: assert property ((key_active_o & ~$past(key_active_o)) != 24'h000000 |->
                                   $past(taken, 1) || $past(taken, 2) || $past(taken, 3))
    else $error("Key became active without a sample");
endmodule

bind touch_key_detect_filter touch_key_detect_filter_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .acq_req_o(acq_req_o), .acq_key_o(acq_key_o),
  .acq_valid_i(acq_valid_i), .rd_key_i(rd_key_i), .rd_signal_o(rd_signal_o),
  .rd_reference_o(rd_reference_o), .rd_detect_count_o(rd_detect_count_o),
  .key_active_o(key_active_o), .scan_done_o(scan_done_o));

// >>> acq_front_end_model.sv
// Behavioural acquisition front end answering the filter's sample requests.
// Assumes requests change after rising edges; it answers after falling edges.
`timescale 1ns/100ps
module acq_front_end_model (
  input  wire logic              clk_i,      // Filter clock
  input  wire logic              req_i,      // Sample request
  input  wire logic [4:0]        key_i,      // Key to sample
  input  wire logic [3:0]        delay_i,    // Wait cycles before answering
  input  wire logic [23:0][15:0] sig_tab_i,  // Signal per key
  output logic                   valid_o,    // One-cycle sample strobe
  output logic [15:0]            signal_o    // Sample value
);
  logic [3:0] wait_cnt;

  initial begin
    valid_o = 1'b0;
    signal_o = 16'h0000;
    wait_cnt = 4'h0;
  end

  always @(negedge clk_i) begin
    if (req_i && !valid_o && wait_cnt >= delay_i) begin
      valid_o  <= 1'b1;
      signal_o <= sig_tab_i[key_i];
      wait_cnt <= 4'h0;
    end else begin
      valid_o  <= 1'b0;
      // Stale data toggles so it never passes for a fresh sample
      signal_o <= ~signal_o;
      wait_cnt <= req_i ? wait_cnt + 4'h1 : 4'h0;
    end
  end
endmodule

// >>> touch_key_detect_filter_tb_top.sv
// Self-checking bench for the touch key filter with a modelled front end.
// Assumes a 10-cycle tick so drift and rise delays end within a few thousand cycles.
`timescale 1ns/100ps
module touch_key_detect_filter_tb_top;
  localparam logic [15:0] BASE = 16'h0400;
  logic              ref_clk_i = 1'b0;
  logic              rst_n_i = 1'b0;
  logic              acq_req_o;
  logic [4:0]        acq_key_o;
  logic              acq_valid_i;
  logic [15:0]       acq_signal_i;
  logic              cfg_we_i = 1'b0;
  logic [4:0]        cfg_key_i = 5'h00;
  logic [2:0]        cfg_field_i = 3'h0;
  logic [7:0]        cfg_data_i = 8'h00;
  logic              cal_all_i = 1'b0;
  logic [4:0]        rd_key_i = 5'h00;
  logic [15:0]       rd_signal_o;
  logic [15:0]       rd_reference_o;
  logic [3:0]        rd_detect_count_o;
  logic [23:0]       key_active_o;
  logic              scan_done_o;
  logic [3:0]        delay = 4'h0;
  logic [23:0][15:0] sig_tab;
  int                take_cnt [24];
  int                num_errors = 0;
  int                cmp_count = 0;

  always #20 ref_clk_i = ~ref_clk_i;

  touch_key_detect_filter #(.TICK_CYCLES(10)) uut (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .acq_req_o(acq_req_o), .acq_key_o(acq_key_o),
    .acq_valid_i(acq_valid_i), .acq_signal_i(acq_signal_i), .cfg_we_i(cfg_we_i), .cfg_key_i(cfg_key_i),
    .cfg_field_i(cfg_field_i), .cfg_data_i(cfg_data_i), .cal_all_i(cal_all_i), .rd_key_i(rd_key_i),
    .rd_signal_o(rd_signal_o), .rd_reference_o(rd_reference_o), .rd_detect_count_o(rd_detect_count_o),
    .key_active_o(key_active_o), .scan_done_o(scan_done_o));

  acq_front_end_model front_end (
    .clk_i(ref_clk_i), .req_i(acq_req_o), .key_i(acq_key_o), .delay_i(delay),
    .sig_tab_i(sig_tab), .valid_o(acq_valid_i), .signal_o(acq_signal_i));

  always @(posedge ref_clk_i) begin
    if (acq_req_o === 1'b1 && acq_valid_i === 1'b1) take_cnt[acq_key_o]++;
  end

  task automatic wrap_up();
    $display("Comparisons %0d, errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_scans(input int n);
    int t;
    for (int i = 0; i < n; i++) begin
      t = 0;
      do begin
        @(negedge ref_clk_i);
        t++;
      end while (scan_done_o !== 1'b1 && t < 3000);
      if (t >= 3000) begin
        num_errors++;
        $display("Error scan_done timeout");
        wrap_up();
      end
    end
  endtask

  task automatic cfg(input logic [4:0] k, input touch_key_pkg::cfg_field_t f, input logic [7:0] d);
    cfg_we_i = 1'b1;
    cfg_key_i = k;
    cfg_field_i = f;
    cfg_data_i = d;
    @(negedge ref_clk_i);
    cfg_we_i = 1'b0;
    @(negedge ref_clk_i);
  endtask

  task automatic rd(input logic [4:0] k);
    rd_key_i = k;
    @(negedge ref_clk_i);
  endtask

  task automatic clear_takes();
    foreach (take_cnt[k]) take_cnt[k] = 0;
  endtask

  initial begin
    for (int k = 0; k < 24; k++) sig_tab[k] = BASE;
    repeat (3) @(negedge ref_clk_i);
    check("active in reset", 24'h000000, key_active_o);
    rst_n_i = 1'b1;
    wait_scans(2);
    rd(5'h03);
    check("reference key 3", BASE, rd_reference_o);
    check("signal key 3", BASE, rd_signal_o);
    rd(5'h18);
    check("reference key 24", 24'h000000, rd_reference_o);
    // Default settings with a slow front end
    delay = 4'h2;
    wait_scans(1);
    sig_tab[5] = BASE - 16'h000a;
    sig_tab[6] = BASE - 16'h0009;
    clear_takes();
    wait_scans(1);
    check("takes key 5", 24'h000005, 24'(take_cnt[5]));
    check("takes key 6", 24'h000001, 24'(take_cnt[6]));
    check("active scan 1", 24'h000000, key_active_o);
    rd(5'h05);
    check("count key 5", 24'h000001, rd_detect_count_o);
    wait_scans(1);
    check("active scan 2", 24'h000020, key_active_o);
    sig_tab[5] = BASE - 16'h0009;
    wait_scans(2);
    check("active in hysteresis", 24'h000020, key_active_o);
    sig_tab[5] = BASE - 16'h0008;
    wait_scans(2);
    check("active released", 24'h000000, key_active_o);
    rd(5'h05);
    check("count released", 24'h000000, rd_detect_count_o);
    // Per-key thresholds and limits
    cfg(5'h0a, touch_key_pkg::CFG_TOUCH_THRESHOLD, 8'h0c);
    cfg(5'h0b, touch_key_pkg::CFG_TOUCH_THRESHOLD, 8'h0c);
    cfg(5'h0c, touch_key_pkg::CFG_FAST_LIMIT, 8'h01);
    cfg(5'h0d, touch_key_pkg::CFG_FAST_LIMIT, 8'h0f);
    cfg(5'h0e, touch_key_pkg::CFG_NORMAL_LIMIT, 8'h00);
    cfg(5'h0f, touch_key_pkg::CFG_NORMAL_LIMIT, 8'h01);
    cfg(5'h0f, touch_key_pkg::CFG_FAST_LIMIT, 8'h03);
    wait_scans(1);
    sig_tab[10] = BASE - 16'h000f;
    for (int k = 11; k < 16; k++) sig_tab[k] = BASE - 16'h0010;
    clear_takes();
    wait_scans(1);
    check("takes key 10", 24'h000001, 24'(take_cnt[10]));
    check("takes key 11", 24'h000005, 24'(take_cnt[11]));
    check("takes key 12", 24'h000001, 24'(take_cnt[12]));
    check("takes key 13", 24'h00000f, 24'(take_cnt[13]));
    check("takes key 14", 24'h000000, 24'(take_cnt[14]));
    check("takes key 15", 24'h000003, 24'(take_cnt[15]));
    wait_scans(1);
    check("active limits", 24'h00b800, key_active_o);
    // Drift and rise recalibration after a fresh calibration
    delay = 4'h0;
    for (int k = 0; k < 24; k++) sig_tab[k] = BASE;
    cfg(5'h05, touch_key_pkg::CFG_FALLING_DRIFT, 8'h03);
    cfg(5'h05, touch_key_pkg::CFG_RISING_DRIFT, 8'h02);
    cal_all_i = 1'b1;
    @(negedge ref_clk_i);
    cal_all_i = 1'b0;
    wait_scans(2);
    sig_tab[5] = BASE - 16'h0014;
    sig_tab[7] = BASE + 16'h0003;
    sig_tab[8] = BASE - 16'h0003;
    sig_tab[9] = BASE + 16'h0007;
    repeat (100) @(negedge ref_clk_i);
    rd(5'h09);
    check("rise early", BASE, rd_reference_o);
    repeat (200) @(negedge ref_clk_i);
    rd(5'h07);
    check("rising drift early", BASE, rd_reference_o);
    repeat (200) @(negedge ref_clk_i);
    rd(5'h09);
    check("rise recalibrated", BASE + 16'h0007, rd_reference_o);
    repeat (250) @(negedge ref_clk_i);
    rd(5'h07);
    check("rising drift step", BASE + 16'h0001, rd_reference_o);
    rd(5'h05);
    check("no drift in touch", BASE, rd_reference_o);
    repeat (1250) @(negedge ref_clk_i);
    rd(5'h08);
    check("falling drift early", BASE, rd_reference_o);
    repeat (900) @(negedge ref_clk_i);
    rd(5'h08);
    check("falling drift step", BASE - 16'h0001, rd_reference_o);
    // Only the raised reference makes this a touch
    sig_tab[9] = BASE - 16'h0003;
    wait_scans(3);
    check("active key 9", 24'h000001, {23'h000000, key_active_o[9]});
    wrap_up();
  end
endmodule
